/* File: pkg/pbc_pkg.sv */
// Package for the two general-purpose ports: register map, reset values, carriers.
package pbc_pkg;

  // ****************************************
  // Register bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORT_W = 8;

  // Address is {bank, offset}; banks let printed offsets that coincide stay apart.
  localparam logic [3:0] BANK_0 = 4'h0;
  localparam logic [3:0] BANK_1 = 4'h1;
  localparam logic [3:0] BANK_3 = 4'h3;

  localparam logic [7:0] OFS_PORT_A_DATA_AND_PULLUP_CTRL_CTRL = 8'h10;
  localparam logic [7:0] OFS_B_DIR      = 8'h11;
  localparam logic [7:0] OFS_B_DATA     = 8'h12;
  localparam logic [7:0] OFS_C_DIR      = 8'h10;
  localparam logic [7:0] OFS_C_DATA     = 8'h11;
  localparam logic [7:0] OFS_IRQ_FLAGS1 = 8'h16;
  localparam logic [7:0] OFS_IRQ_ENA1   = 8'h17;
  localparam logic [7:0] OFS_TMR_CTRL2  = 8'h17;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned BIT_PULLUP_DIS = 7;
  localparam int unsigned BIT_CHANGE     = 7;
  localparam int unsigned BIT_PWM_OUTPUT_ONE_ON    = 4;
  localparam int unsigned BIT_PWM_OUTPUT_TWO_ON    = 5;

  localparam int unsigned PIN_CAPTURE_INPUT_ONE  = 0;
  localparam int unsigned PIN_CAPTURE_INPUT_TWO  = 1;
  localparam int unsigned PIN_PWM_OUTPUT_ONE  = 2;
  localparam int unsigned PIN_PWM_OUTPUT_TWO  = 3;
  localparam int unsigned PIN_TCK12 = 4;
  localparam int unsigned PIN_TCK3  = 5;
  localparam int unsigned PIN_SCK   = 6;
  localparam int unsigned PIN_SDO   = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] DIR_RST        = 8'hFF;
  localparam logic [7:0] LATCH_RST      = 8'h00;
  localparam logic [7:0] REG_RST        = 8'h00;
  localparam logic       PULLUP_DIS_RST = 1'b0;
  localparam logic       FLAG_RST       = 1'b0;

  // ****************************************
  // Processor mode from configuration bits
  // ****************************************
  typedef enum logic [1:0] {
    MODE_MICROPROC = 2'b00,
    MODE_EXT_MCU   = 2'b01,
    MODE_MCU       = 2'b10,
    MODE_MCU_PROT  = 2'b11
  } pbc_mode_e;

  // Drive of one 8-bit pin group.
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } pbc_drive_s;

  // Peripheral signals that may take over first-port pins.
  typedef struct packed {
    logic pwm_output_one;
    logic pwm_output_two;
    logic spi_en;
    logic sck_out;
    logic sck_oe;
    logic sdo;
  } pbc_periph_s;

endpackage : pbc_pkg

/* File: core/pbc_gpio.sv */
// Two 8-bit general-purpose ports with pin sharing; pull-ups and change detection on the first port only.
`timescale 1ns/1ps

module pbc_gpio
  import pbc_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  // Register port
  input  wire logic [pbc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [pbc_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [pbc_pkg::DATA_W-1:0]  rdata_o,
  // First port pins
  input  wire logic [pbc_pkg::PORT_W-1:0]  first_port_pins_i,
  output logic      [pbc_pkg::PORT_W-1:0]  first_port_pins_o,
  output logic      [pbc_pkg::PORT_W-1:0]  first_port_pins_oe_o,
  output logic      [pbc_pkg::PORT_W-1:0]  first_port_pullup_o,
  // Second port pins
  input  wire logic [pbc_pkg::PORT_W-1:0]  second_port_pins_i,
  output logic      [pbc_pkg::PORT_W-1:0]  second_port_pins_o,
  output logic      [pbc_pkg::PORT_W-1:0]  second_port_pins_oe_o,
  // System bus side
  input  wire logic [1:0]                  proc_mode_i,
  input  wire logic [pbc_pkg::PORT_W-1:0]  bus_addr_data_low_byte_i,
  input  wire logic                        bus_addr_data_oe_i,
  output logic      [pbc_pkg::PORT_W-1:0]  bus_addr_data_low_byte_o,
  // Peripheral side
  input  wire pbc_pkg::pbc_periph_s        periph_i,
  output logic                             capture_input_one_o,
  output logic                             capture_input_two_o,
  output logic                             timer12_ext_clock_o,
  output logic                             timer3_ext_clock_o,
  output logic                             spi_sck_in_o,
  output logic                             pwm_output_one_enable_o,
  output logic                             pwm_output_two_enable_o,
  // Events
  output logic                             periph_irq_o,
  output logic                             wake_o
);
  import pbc_pkg::*;

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [3:0]        bank,
                                   input logic [7:0]        ofs);
    reg_hit = (a == {bank, ofs});
  endfunction : reg_hit

  logic wr_port_a_data_and_pullup_ctrl;
  logic wr_b_dir;
  logic wr_b_data;
  logic wr_c_dir;
  logic wr_c_data;
  logic wr_flags;
  logic wr_ena;
  logic wr_tctl;

  assign wr_port_a_data_and_pullup_ctrl  = wr_i && reg_hit(addr_i, BANK_0, OFS_PORT_A_DATA_AND_PULLUP_CTRL_CTRL);
  assign wr_b_dir  = wr_i && reg_hit(addr_i, BANK_0, OFS_B_DIR);
  assign wr_b_data = wr_i && reg_hit(addr_i, BANK_0, OFS_B_DATA);
  assign wr_c_dir  = wr_i && reg_hit(addr_i, BANK_1, OFS_C_DIR);
  assign wr_c_data = wr_i && reg_hit(addr_i, BANK_1, OFS_C_DATA);
  assign wr_flags  = wr_i && reg_hit(addr_i, BANK_1, OFS_IRQ_FLAGS1);
  assign wr_ena    = wr_i && reg_hit(addr_i, BANK_1, OFS_IRQ_ENA1);
  assign wr_tctl   = wr_i && reg_hit(addr_i, BANK_3, OFS_TMR_CTRL2);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PORT_W-1:0] b_meta_r;
  logic [PORT_W-1:0] b_sync_r;
  logic [PORT_W-1:0] c_meta_r;
  logic [PORT_W-1:0] c_sync_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      b_meta_r <= LATCH_RST;
      b_sync_r <= LATCH_RST;
      c_meta_r <= LATCH_RST;
      c_sync_r <= LATCH_RST;
    end else begin
      b_meta_r <= first_port_pins_i;
      b_sync_r <= b_meta_r;
      c_meta_r <= second_port_pins_i;
      c_sync_r <= c_meta_r;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic [PORT_W-1:0] b_dir_r;
  logic [PORT_W-1:0] b_latch_r;
  logic [PORT_W-1:0] c_dir_r;
  logic [PORT_W-1:0] c_latch_r;
  logic              pullup_dis_r;
  logic [DATA_W-1:0] irq_ena_r;
  logic [DATA_W-1:0] tmr_ctrl2_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      b_dir_r <= DIR_RST;
      c_dir_r <= DIR_RST;
    end else begin
      if (wr_b_dir) begin
        b_dir_r <= wdata_i;
      end
      if (wr_c_dir) begin
        c_dir_r <= wdata_i;
      end
    end
  end

  // Latches are not reset on real silicon; a known value keeps simulation clean.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      b_latch_r <= LATCH_RST;
      c_latch_r <= LATCH_RST;
    end else begin
      if (wr_b_data) begin
        b_latch_r <= wdata_i;
      end
      if (wr_c_data) begin
        c_latch_r <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pullup_dis_r <= PULLUP_DIS_RST;
    end else if (wr_port_a_data_and_pullup_ctrl) begin
      pullup_dis_r <= wdata_i[BIT_PULLUP_DIS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_ena_r   <= REG_RST;
      tmr_ctrl2_r <= REG_RST;
    end else begin
      if (wr_ena) begin
        irq_ena_r <= wdata_i;
      end
      if (wr_tctl) begin
        tmr_ctrl2_r <= wdata_i;
      end
    end
  end

  // ****************************************
  // Change detection
  // ****************************************
  logic [PORT_W-1:0] mismatch;
  logic              any_mismatch;
  logic              change_flag_r;

  // inputs only, pin against own latch bit
  assign mismatch = b_dir_r & (b_sync_r ^ b_latch_r);
  assign any_mismatch = |mismatch;

  // A write that clears the flag while a mismatch is present loses, so an edge
  // arriving during the service routine is never dropped.
  // defined reset value
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      change_flag_r <= FLAG_RST;
    end else if (any_mismatch) begin
      change_flag_r <= 1'b1;
    end else if (wr_flags) begin
      change_flag_r <= wdata_i[BIT_CHANGE];
    end
  end

  // ****************************************
  // Interrupt request and wake
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      periph_irq_o <= 1'b0;
      wake_o       <= 1'b0;
    end else begin
      periph_irq_o <= change_flag_r & irq_ena_r[BIT_CHANGE];
      // wake on change, independent of the enable
      wake_o       <= change_flag_r;
    end
  end

  // ****************************************
  // First port pin drive
  // ****************************************
  logic [PORT_W-1:0] b_level;
  logic [PORT_W-1:0] b_oe;
  logic              pwm_output_one_on;
  logic              pwm_output_two_on;

  assign pwm_output_one_on = tmr_ctrl2_r[BIT_PWM_OUTPUT_ONE_ON];
  assign pwm_output_two_on = tmr_ctrl2_r[BIT_PWM_OUTPUT_TWO_ON];

  generate
    for (genvar i = 0; i < PORT_W; i++) begin : g_first_pin
      always_comb begin
        b_level[i] = b_latch_r[i];
        b_oe[i]    = ~b_dir_r[i];
        if (i == PIN_PWM_OUTPUT_ONE && pwm_output_one_on) begin
          b_level[i] = periph_i.pwm_output_one;
          b_oe[i]    = 1'b1;
        end else if (i == PIN_PWM_OUTPUT_TWO && pwm_output_two_on) begin
          b_level[i] = periph_i.pwm_output_two;
          b_oe[i]    = 1'b1;
        end else if (i == PIN_SCK && periph_i.spi_en) begin
          b_level[i] = periph_i.sck_out;
          b_oe[i]    = periph_i.sck_oe;
        end else if (i == PIN_SDO && periph_i.spi_en) begin
          b_level[i] = periph_i.sdo;
          b_oe[i]    = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      first_port_pins_o    <= LATCH_RST;
      first_port_pins_oe_o <= ~DIR_RST;
      first_port_pullup_o  <= {PORT_W{~PULLUP_DIS_RST}};
    end else begin
      first_port_pins_o    <= b_level;
      first_port_pins_oe_o <= b_oe;
      first_port_pullup_o  <= {PORT_W{~pullup_dis_r}} & ~b_oe;
    end
  end

  // alternate functions out of the synchronised pins; pulse-output enables from tmr_ctrl2_r
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      capture_input_one_o <= 1'b0;
      capture_input_two_o <= 1'b0;
      timer12_ext_clock_o <= 1'b0;
      timer3_ext_clock_o  <= 1'b0;
      spi_sck_in_o        <= 1'b0;
      pwm_output_one_enable_o       <= 1'b0;
      pwm_output_two_enable_o       <= 1'b0;
    end else begin
      capture_input_one_o <= b_sync_r[PIN_CAPTURE_INPUT_ONE];
      capture_input_two_o <= b_sync_r[PIN_CAPTURE_INPUT_TWO];
      timer12_ext_clock_o <= b_sync_r[PIN_TCK12];
      timer3_ext_clock_o  <= b_sync_r[PIN_TCK3];
      spi_sck_in_o        <= b_sync_r[PIN_SCK];
      pwm_output_one_enable_o       <= pwm_output_one_on;
      pwm_output_two_enable_o       <= pwm_output_two_on;
    end
  end

  // ****************************************
  // Second port and system bus
  // ****************************************
  logic       bus_mode;
  pbc_drive_s c_drive;

  // bus only in processor or extended modes
  assign bus_mode = (pbc_mode_e'(proc_mode_i) == MODE_MICROPROC) ||
                    (pbc_mode_e'(proc_mode_i) == MODE_EXT_MCU);

  always_comb begin
    if (bus_mode) begin
      c_drive.level = bus_addr_data_low_byte_i;
      c_drive.oe    = {PORT_W{bus_addr_data_oe_i}};
    end else begin
      c_drive.level = c_latch_r;
      c_drive.oe    = ~c_dir_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      second_port_pins_o       <= LATCH_RST;
      second_port_pins_oe_o    <= ~DIR_RST;
      bus_addr_data_low_byte_o <= LATCH_RST;
    end else begin
      second_port_pins_o       <= c_drive.level;
      second_port_pins_oe_o    <= c_drive.oe;
      bus_addr_data_low_byte_o <= c_sync_r;
    end
  end

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = REG_RST;
    if (reg_hit(addr_i, BANK_0, OFS_PORT_A_DATA_AND_PULLUP_CTRL_CTRL)) begin
      rdata_nxt[BIT_PULLUP_DIS] = pullup_dis_r;
    end else if (reg_hit(addr_i, BANK_0, OFS_B_DIR)) begin
      rdata_nxt = b_dir_r;
    end else if (reg_hit(addr_i, BANK_0, OFS_B_DATA)) begin
      rdata_nxt = b_sync_r;
    end else if (reg_hit(addr_i, BANK_1, OFS_C_DIR)) begin
      rdata_nxt = c_dir_r;
    end else if (reg_hit(addr_i, BANK_1, OFS_C_DATA)) begin
      rdata_nxt = c_sync_r;
    end else if (reg_hit(addr_i, BANK_1, OFS_IRQ_FLAGS1)) begin
      rdata_nxt[BIT_CHANGE] = change_flag_r;
    end else if (reg_hit(addr_i, BANK_1, OFS_IRQ_ENA1)) begin
      rdata_nxt = irq_ena_r;
    end else if (reg_hit(addr_i, BANK_3, OFS_TMR_CTRL2)) begin
      rdata_nxt = tmr_ctrl2_r;
    end
  end

  // Read data stands only in the cycle after the strobe; otherwise zero.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o <= REG_RST;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= REG_RST;
    end
  end

endmodule : pbc_gpio

/* File: sim/pbc_gpio_props.sv */
// Checker for the two general-purpose ports, bound to the top module.
`timescale 1ns/1ps
module pbc_gpio_props
  import pbc_pkg::*;
(
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       resetn_i,
  // Register port
  input wire logic [pbc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pbc_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [pbc_pkg::DATA_W-1:0] rdata_o,
  // Pins
  input wire logic [pbc_pkg::PORT_W-1:0] first_port_pins_i,
  input wire logic [pbc_pkg::PORT_W-1:0] first_port_pins_o,
  input wire logic [pbc_pkg::PORT_W-1:0] first_port_pins_oe_o,
  input wire logic [pbc_pkg::PORT_W-1:0] first_port_pullup_o,
  input wire logic [pbc_pkg::PORT_W-1:0] second_port_pins_i,
  input wire logic [pbc_pkg::PORT_W-1:0] second_port_pins_o,
  input wire logic [pbc_pkg::PORT_W-1:0] second_port_pins_oe_o,
  // Bus, peripherals and events
  input wire logic [1:0]                 proc_mode_i,
  input wire logic [pbc_pkg::PORT_W-1:0] bus_addr_data_low_byte_i,
  input wire logic                       bus_addr_data_oe_i,
  input wire pbc_pkg::pbc_periph_s       periph_i,
  input wire logic                       capture_input_one_o,
  input wire logic                       pwm_output_one_enable_o,
  input wire logic                       pwm_output_two_enable_o,
  input wire logic                       periph_irq_o,
  input wire logic                       wake_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  pullup_out_a: assert property (
    (first_port_pullup_o & first_port_pins_oe_o) == 8'h00)
    else $error("pull-up on while pin drives");
  reset_state_a: assert property (
    !$past(resetn_i) |-> first_port_pins_oe_o == 8'h00 && second_port_pins_oe_o == 8'h00
      && first_port_pullup_o == 8'hFF)
    else $error("pins not inputs with pull-ups after reset");
  dir_drive_a: assert property (
    $past(wr_i, 2) && $past(addr_i, 2) == 12'h011 && !periph_i.spi_en && !pwm_output_one_enable_o
      && !pwm_output_two_enable_o |-> first_port_pins_oe_o == ~$past(wdata_i, 2))
    else $error("direction write not seen on drive enables");
  pullup_ctl_a: assert property (
    $past(wr_i, 2) && $past(addr_i, 2) == 12'h010
      |-> first_port_pullup_o == ($past(wdata_i[7], 2) ? 8'h00 : ~first_port_pins_oe_o))
    else $error("pull-ups do not follow the global disable");
  read_first_a: assert property (
    $past(resetn_i, 3) && $past(rd_i) && $past(addr_i) == 12'h012
      |-> rdata_o == $past(first_port_pins_i, 3))
    else $error("first port read is not the synchronised pins");
  read_second_a: assert property (
    $past(resetn_i, 3) && $past(rd_i) && $past(addr_i) == 12'h111
      |-> rdata_o == $past(second_port_pins_i, 3))
    else $error("second port read is not the synchronised pins");
  capture_sync_a: assert property (
    $past(resetn_i, 3) |-> capture_input_one_o == $past(first_port_pins_i[0], 3))
    else $error("capture input not three cycles behind pin");
  pwm_take_a: assert property (
    pwm_output_one_enable_o && $past(pwm_output_one_enable_o)
      |-> first_port_pins_oe_o[2] && first_port_pins_o[2] == $past(periph_i.pwm_output_one))
    else $error("enabled pulse output does not own its pin");
  bus_mode_a: assert property (
    !proc_mode_i[1] && !$past(proc_mode_i[1])
      |-> second_port_pins_oe_o == {8{$past(bus_addr_data_oe_i)}}
      && (!$past(bus_addr_data_oe_i) || second_port_pins_o == $past(bus_addr_data_low_byte_i)))
    else $error("second port not carrying the system bus");
  irq_flag_a: assert property (
    periph_irq_o |-> wake_o)
    else $error("request raised without the change flag");

  pwm_cov: cover property (pwm_output_one_enable_o && first_port_pins_oe_o[2]);
  irq_cov: cover property ($rose(periph_irq_o));
  bus_cov: cover property (!proc_mode_i[1] && bus_addr_data_oe_i);
endmodule : pbc_gpio_props

/* File: sim/pbc_pin_partner.sv */
// Far-side model of eight pins: keys that force a level, pull-ups and released lines.
`timescale 1ns/1ps
module pbc_pin_partner (
  // Clock
  input  wire logic       clk_i,
  // Device drive
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  // Keys
  input  wire logic [7:0] key_i,
  input  wire logic [7:0] key_en_i,
  // Resolved levels
  output logic      [7:0] pins_o
);
  // A known start keeps an undriven line from toggling between unknowns forever.
  logic [7:0] last_r = 8'h00;
  // key first, then device drive, then pull-up, then toggle
  // A pressed key is a hard short, so it wins even over a driven pin.
  // A released line with no pull-up toggles, so a stale level never matches by luck.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (key_en_i[i]) pins_o[i] = key_i[i];
      else if (oe_i[i]) pins_o[i] = drive_i[i];
      else if (pullup_i[i]) pins_o[i] = 1'b1;
      else pins_o[i] = ~last_r[i];
    end
  end
  always_ff @(posedge clk_i) begin
    last_r <= pins_o;
  end
endmodule : pbc_pin_partner

/* File: sim/pbc_gpio_tb.sv */
// Self-checking testbench for the two general-purpose ports.
`timescale 1ns/1ps
module pbc_gpio_tb;
  import pbc_pkg::*;
  logic clk_i, resetn_i, wr_i, rd_i, bus_oe, pwm_output_one_en, pwm_output_two_en, irq, wake, capture_input_one, tck12;
  logic [11:0] addr_i;
  logic [7:0]  wdata_i, rdata, p1, p1_o, p1_oe, p1_pu, p2, p2_o, p2_oe, bus_d, bus_q;
  logic [7:0]  key1, key1_en, key2, key2_en, d;
  logic [1:0]  mode;
  pbc_periph_s periph;
  int failures, checks_done;

  pbc_gpio i_pbc_gpio (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .first_port_pins_i(p1), .first_port_pins_o(p1_o), .first_port_pins_oe_o(p1_oe),
    .first_port_pullup_o(p1_pu), .second_port_pins_i(p2), .second_port_pins_o(p2_o),
    .second_port_pins_oe_o(p2_oe), .proc_mode_i(mode), .bus_addr_data_low_byte_i(bus_d),
    .bus_addr_data_oe_i(bus_oe), .bus_addr_data_low_byte_o(bus_q), .periph_i(periph),
    .capture_input_one_o(capture_input_one), .capture_input_two_o(), .timer12_ext_clock_o(tck12),
    .timer3_ext_clock_o(), .spi_sck_in_o(), .pwm_output_one_enable_o(pwm_output_one_en),
    .pwm_output_two_enable_o(pwm_output_two_en), .periph_irq_o(irq), .wake_o(wake));
  pbc_pin_partner i_pbc_pin_partner_1 (.clk_i(clk_i), .drive_i(p1_o), .oe_i(p1_oe),
    .pullup_i(p1_pu), .key_i(key1), .key_en_i(key1_en), .pins_o(p1));
  pbc_pin_partner i_pbc_pin_partner_2 (.clk_i(clk_i), .drive_i(p2_o), .oe_i(p2_oe),
    .pullup_i(8'h00), .key_i(key2), .key_en_i(key2_en), .pins_o(p2));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : settle

  // Read-write the port data so latch equals pins, then clear the flag.
  task automatic resync();
    logic [7:0] v;
    rd(12'h012, v);
    wr(12'h012, v);
    wr(12'h116, 8'h00);
  endtask : resync

  task automatic wait_wake(input logic exp);
    int n;
    for (n = 0; n < 20 && wake !== exp; n++) @(posedge clk_i);
    chk({7'h00, wake}, {7'h00, exp});
  endtask : wait_wake

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end

  initial begin
    resetn_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 12'h000; wdata_i = 8'h00;
    mode = 2'b10; bus_oe = 1'b0; bus_d = 8'h00; periph = '0;
    key1 = 8'h00; key1_en = 8'h00; key2 = 8'h00; key2_en = 8'h00;
    failures = 0; checks_done = 0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    chk(p1_pu, 8'hFF);
    chk(p1_oe, 8'h00);
    rd_chk(12'h011, 8'hFF);
    rd_chk(12'h110, 8'hFF);
    rd_chk(12'h117, 8'h00);
    rd_chk(12'h316, 8'h00);
    wait_wake(1'b1);
    rd_chk(12'h012, 8'hFF);
    wr(12'h116, 8'h00);
    rd_chk(12'h116, 8'h80);
    resync();
    rd_chk(12'h116, 8'h00);
    wr(12'h117, 8'h80);
    key1_en <= 8'h08;
    wait_wake(1'b1);
    settle();
    chk({7'h00, irq}, 8'h01);
    rd_chk(12'h012, 8'hF7);
    resync();
    settle();
    chk({7'h00, irq}, 8'h00);
    wr(12'h011, 8'hF7);
    wr(12'h012, 8'hFF);
    settle();
    chk(p1_oe, 8'h08);
    chk(p1_pu, 8'hF7);
    chk(p1_o & 8'h08, 8'h08);
    rd_chk(12'h116, 8'h00);
    wr(12'h010, 8'h80);
    settle();
    chk(p1_pu, 8'h00);
    rd_chk(12'h010, 8'h80);
    wr(12'h010, 8'h00);
    wr(12'h011, 8'hFF);
    key1_en <= 8'h00;
    settle();
    chk(p1_pu, 8'hFF);
    resync();
    wr(12'h111, 8'h3C);
    wr(12'h110, 8'h0F);
    key2 <= 8'h0A; key2_en <= 8'h0F;
    settle();
    chk(p2_oe, 8'hF0);
    rd_chk(12'h111, 8'h3A);
    bus_d <= 8'h5A; bus_oe <= 1'b1; key2_en <= 8'h00;
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      settle();
      chk(p2_oe, m[1] ? 8'hF0 : 8'hFF);
      if (!m[1]) chk(bus_q, 8'h5A);
      chk(p2_o, m[1] ? 8'h3C : 8'h5A);
    end
    mode <= 2'b10; key1 <= 8'h00; key1_en <= 8'h01;
    wr(12'h317, 8'h30);
    periph <= '{pwm_output_one: 1'b1, pwm_output_two: 1'b0, spi_en: 1'b1, sck_out: 1'b0, sck_oe: 1'b1, sdo: 1'b1};
    settle();
    chk({6'h00, pwm_output_two_en, pwm_output_one_en}, 8'h03);
    chk(p1_oe & 8'hCC, 8'hCC);
    chk(p1_o & 8'hCC, 8'h84);
    chk({6'h00, tck12, capture_input_one}, 8'h02);
    summarize();
  end
endmodule : pbc_gpio_tb

bind pbc_gpio pbc_gpio_props i_pbc_gpio_props (.clk_i(clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .first_port_pins_i(first_port_pins_i), .first_port_pins_o(first_port_pins_o),
  .first_port_pins_oe_o(first_port_pins_oe_o), .first_port_pullup_o(first_port_pullup_o),
  .second_port_pins_i(second_port_pins_i), .second_port_pins_o(second_port_pins_o),
  .second_port_pins_oe_o(second_port_pins_oe_o), .proc_mode_i(proc_mode_i),
  .bus_addr_data_low_byte_i(bus_addr_data_low_byte_i),
  .bus_addr_data_oe_i(bus_addr_data_oe_i), .periph_i(periph_i),
  .capture_input_one_o(capture_input_one_o), .pwm_output_one_enable_o(pwm_output_one_enable_o),
  .pwm_output_two_enable_o(pwm_output_two_enable_o), .periph_irq_o(periph_irq_o), .wake_o(wake_o));
